/* ssx_defs.svh */
/*
 * Constants of the slot integer exchange: register offsets, bit
 * positions of the command and status words, reset values.
 * Assumes inclusion by bare name from the design.
 */
`ifndef SSX_DEFS_SVH
`define SSX_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets and address region codes (address bits 7:5)
// ----------------------------------------------------------------
`define SSX_OFF_CTRL    8'h00
`define SSX_OFF_TARE    8'h04
`define SSX_OFF_TARGET  8'h08
`define SSX_OFF_MSG     8'h0C
`define SSX_REG_OUTW    3'h1
`define SSX_REG_INW     3'h2

// ----------------------------------------------------------------
// command word fields
// ----------------------------------------------------------------
`define SSX_CMD_SEL_LSB 0
`define SSX_CMD_LD_TARE 3
`define SSX_CMD_CLR_TARE 4
`define SSX_CMD_TARE    5
`define SSX_CMD_PRINT   6
`define SSX_CMD_ZERO    7
`define SSX_CMD_TARGET  8
`define SSX_CMD_MSG_LSB 9
`define SSX_CMD_OUT_LSB 12
`define SSX_CMD_LD_TGT  15

// ----------------------------------------------------------------
// status word fields and message register prompt bit
// ----------------------------------------------------------------
`define SSX_ST_TGT_LSB  0
`define SSX_ST_CMP_LSB  3
`define SSX_ST_ENTER    8
`define SSX_ST_IN_LSB   9
`define SSX_ST_MOTION   12
`define SSX_ST_NET      13
`define SSX_ST_BUSY     14
`define SSX_ST_OK       15
`define SSX_MSG_PROMPT_BIT 3

// ----------------------------------------------------------------
// select codes, display codes and reset values
// ----------------------------------------------------------------
`define SSX_SEL_GROSS   3'h0
`define SSX_SEL_NET     3'h1
`define SSX_SEL_DISP    3'h2
`define SSX_SEL_TARE    3'h3
`define SSX_SEL_TARGET  3'h4
`define SSX_SEL_RATE    3'h5
`define SSX_MSG_NONE    3'h0
`define SSX_MSG_PROMPT  3'h6
`define SSX_SLOTS_RST   2'h0
`define SSX_WORD_RST    16'h0000

`endif

/* ssx_pkg.sv */
/*
 * Types of the slot integer exchange.
 * Assumes ssx_defs.svh sits in the same folder.
 */
package ssx_pkg;
    typedef enum logic [1:0] {
        SSX_IDLE = 2'b00,
        SSX_CMD  = 2'b01,
        SSX_FILL = 2'b10
    } ssx_state_t;

    typedef logic [15:0] ssx_word_t;
    typedef logic [1:0]  ssx_slot_t;
endpackage

/* ssx_exchange.sv */
/*
 * Slot integer exchange of a weighing indicator: holds the
 * controller's download and command words of up to four slots,
 * acts on slot 0 command edges once per interface update cycle, and
 * builds the weight and status words returned per slot.
 * Assumes an Avalon-MM master on CLK_I, update and conversion
 * ticks from indicator logic on the same clock, and raw discrete
 * input pins.
 */
`timescale 1ns/1ps
`include "ssx_defs.svh"

module ssx_exchange (
    input  wire logic        CLK_I,
    input  wire logic        NRST_I,
    input  wire logic [7:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    input  wire logic [3:0]  AVS_BYTEENABLE_I,
    output logic      [31:0] AVS_READDATA_O,
    output logic             AVS_WAITREQUEST_O,
    input  wire logic        UPD_TICK_I,
    input  wire logic        CONV_TICK_I,
    input  wire logic [15:0] GROSS_I,
    input  wire logic [15:0] DISP_I,
    input  wire logic [15:0] RATE_I,
    input  wire logic [2:0]  TGT_STATE_I,
    input  wire logic [4:0]  CMP_I,
    input  wire logic [2:0]  DIN_I,
    input  wire logic        ENTER_KEY_I,
    input  wire logic        MOTION_I,
    input  wire logic        POWERUP_I,
    input  wire logic        SETUP_I,
    input  wire logic        OVER_CAP_I,
    input  wire logic        UNDER_ZERO_I,
    input  wire logic        X10_I,
    input  wire logic        ZERO_RANGE_OK_I,
    input  wire logic [2:0]  OWN_OUT_EN_I,
    input  wire logic [2:0]  OWN_OUT_I,
    output logic      [2:0]  DOUT_O,
    output logic             PRINT_REQ_O,
    output logic             ZERO_REQ_O,
    output logic             TGT_START_O,
    output logic             TGT_ABORT_O,
    output logic      [15:0] TARGET_VAL_O,
    output logic      [15:0] TARE_VAL_O,
    output logic             NET_MODE_O,
    output logic             MSG_START_O,
    output logic      [2:0]  DISPLAY_CODE_O,
    output logic             PROMPT_FLAG_O,
    output logic             UPD_BUSY_O
);

    // ------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync;
    logic       rst_n;
    logic [2:0] din_s1;
    logic [2:0] din_s2;

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            din_s1 <= 3'b000;
            din_s2 <= 3'b000;
        end else begin
            din_s1 <= DIN_I;
            din_s2 <= din_s1;
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ssx_pkg::ssx_state_t state;
    ssx_pkg::ssx_slot_t  slots_m1;
    ssx_pkg::ssx_word_t  out_word [4];
    ssx_pkg::ssx_word_t  cmd_word [4];
    ssx_pkg::ssx_word_t  in_word  [4];
    ssx_pkg::ssx_word_t  st_word  [4];
    ssx_pkg::ssx_word_t  cmd_snap;
    ssx_pkg::ssx_word_t  out_snap;
    ssx_pkg::ssx_word_t  cmd_prev;
    logic [15:0] tare_reg;
    logic [15:0] target_reg;
    logic        net_mode;
    logic        enter_flag;
    logic        prompt_flag;
    logic [2:0]  disp_code;
    logic [2:0]  din_conv;
    logic [2:0]  dout_req;
    logic        bus_ack;
    logic [31:0] next_rdata;
    logic [15:0] rise;
    logic [15:0] fall;
    logic        data_ok;
    logic [15:0] net_wt;
    logic        msg_change;
    logic        prompt_clr;

    // ------------------------------------------------------------
    // update cycle sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state <= ssx_pkg::SSX_IDLE;
        end else begin
            case (state)
                ssx_pkg::SSX_IDLE: begin
                    if (UPD_TICK_I) begin
                        state <= ssx_pkg::SSX_CMD;
                    end
                end
                ssx_pkg::SSX_CMD:  state <= ssx_pkg::SSX_FILL;
                ssx_pkg::SSX_FILL: state <= ssx_pkg::SSX_IDLE;
                default:           state <= ssx_pkg::SSX_IDLE;
            endcase
        end
    end

    // busy spans edge handling and word rebuild
    assign UPD_BUSY_O = (state != ssx_pkg::SSX_IDLE);

    // snapshot at the tick so a bus write mid-cycle cannot tear
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            cmd_snap <= `SSX_WORD_RST;
            out_snap <= `SSX_WORD_RST;
            cmd_prev <= `SSX_WORD_RST;
        end else if (state == ssx_pkg::SSX_IDLE && UPD_TICK_I) begin
            cmd_snap <= cmd_word[0];
            out_snap <= out_word[0];
        end else if (state == ssx_pkg::SSX_CMD) begin
            cmd_prev <= cmd_snap;
        end
    end

    assign rise = (state == ssx_pkg::SSX_CMD) ? (cmd_snap & ~cmd_prev)
                                              : 16'h0000;
    assign fall = (state == ssx_pkg::SSX_CMD) ? (~cmd_snap & cmd_prev)
                                              : 16'h0000;

    // ------------------------------------------------------------
    // tare, net mode, target
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            tare_reg <= `SSX_WORD_RST;
            net_mode <= 1'b0;
        end else if (rise[`SSX_CMD_LD_TARE]) begin
            tare_reg <= out_snap;
            net_mode <= 1'b1;
        end else if (rise[`SSX_CMD_CLR_TARE]) begin
            tare_reg <= `SSX_WORD_RST;
            net_mode <= 1'b0;
        end else if (rise[`SSX_CMD_TARE] && !MOTION_I) begin
            tare_reg <= GROSS_I;
            net_mode <= 1'b1;
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            target_reg <= `SSX_WORD_RST;
        end else if (rise[`SSX_CMD_LD_TGT]) begin
            target_reg <= out_snap;
        end
    end

    // ------------------------------------------------------------
    // one-cycle requests toward indicator logic
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            PRINT_REQ_O <= 1'b0;
            ZERO_REQ_O  <= 1'b0;
            TGT_START_O <= 1'b0;
            TGT_ABORT_O <= 1'b0;
            MSG_START_O <= 1'b0;
        end else begin
            PRINT_REQ_O <= rise[`SSX_CMD_PRINT];
            ZERO_REQ_O  <= rise[`SSX_CMD_ZERO] && ZERO_RANGE_OK_I;
            TGT_START_O <= rise[`SSX_CMD_TARGET];
            TGT_ABORT_O <= fall[`SSX_CMD_TARGET];
            MSG_START_O <= msg_change
                && cmd_prev[`SSX_CMD_MSG_LSB +: 3] == `SSX_MSG_NONE
                && cmd_snap[`SSX_CMD_MSG_LSB +: 3] != `SSX_MSG_NONE;
        end
    end

    // ------------------------------------------------------------
    // message display
    // ------------------------------------------------------------
    assign msg_change = (state == ssx_pkg::SSX_CMD)
        && (cmd_snap[`SSX_CMD_MSG_LSB +: 3] != cmd_prev[`SSX_CMD_MSG_LSB +: 3]);

    // a held nonzero code never restarts; the field must pass zero
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            disp_code <= `SSX_MSG_NONE;
        end else if (msg_change
                     && cmd_prev[`SSX_CMD_MSG_LSB +: 3] == `SSX_MSG_NONE) begin
            disp_code <= cmd_snap[`SSX_CMD_MSG_LSB +: 3];
        end
    end

    assign prompt_clr = AVS_WRITE_I && bus_ack && AVS_BYTEENABLE_I[0]
        && AVS_ADDRESS_I == `SSX_OFF_MSG
        && AVS_WRITEDATA_I[`SSX_MSG_PROMPT_BIT];

    // set wins over software clear
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            prompt_flag <= 1'b0;
        end else if (msg_change
                     && cmd_prev[`SSX_CMD_MSG_LSB +: 3] == `SSX_MSG_NONE
                     && cmd_snap[`SSX_CMD_MSG_LSB +: 3] == `SSX_MSG_PROMPT) begin
            prompt_flag <= 1'b1;
        end else if (prompt_clr) begin
            prompt_flag <= 1'b0;
        end
    end

    // key press wins over a clear in the same cycle
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            enter_flag <= 1'b0;
        end else if (ENTER_KEY_I) begin
            enter_flag <= 1'b1;
        end else if (msg_change) begin
            enter_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // discrete I/O at conversion rate
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            dout_req <= 3'b000;
        end else if (state == ssx_pkg::SSX_CMD) begin
            dout_req <= cmd_snap[`SSX_CMD_OUT_LSB +: 3];
        end
    end

    // lag up to one conversion period is inherent, not a fault
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            DOUT_O   <= 3'b000;
            din_conv <= 3'b000;
        end else if (CONV_TICK_I) begin
            DOUT_O   <= (OWN_OUT_EN_I & OWN_OUT_I)
                      | (~OWN_OUT_EN_I & dout_req);
            din_conv <= din_s2;
        end
    end

    // ------------------------------------------------------------
    // response words, one generate slice per slot
    // ------------------------------------------------------------
    assign data_ok = !(POWERUP_I || SETUP_I || OVER_CAP_I
                       || UNDER_ZERO_I || X10_I);
    assign net_wt  = GROSS_I - tare_reg;

    for (genvar s = 0; s < 4; s++) begin : g_slot
        logic [15:0] pick;

        always_comb begin
            case (cmd_word[s][`SSX_CMD_SEL_LSB +: 3])
                `SSX_SEL_NET:    pick = net_wt;
                `SSX_SEL_DISP:   pick = DISP_I;
                `SSX_SEL_TARE:   pick = tare_reg;
                `SSX_SEL_TARGET: pick = target_reg;
                `SSX_SEL_RATE:   pick = RATE_I;
                default:         pick = GROSS_I;
            endcase
        end

        always_ff @(posedge CLK_I or negedge rst_n) begin
            if (!rst_n) begin
                in_word[s] <= `SSX_WORD_RST;
                st_word[s] <= `SSX_WORD_RST;
            end else if (state == ssx_pkg::SSX_FILL) begin
                in_word[s] <= data_ok ? pick : `SSX_WORD_RST;
                st_word[s] <= {data_ok,
                               1'b0,
                               net_mode,
                               MOTION_I,
                               din_conv,
                               enter_flag,
                               CMP_I[0], CMP_I[1], CMP_I[2],
                               CMP_I[3], CMP_I[4],
                               TGT_STATE_I};
            end
        end
    end

    // ------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, then answer
    // ------------------------------------------------------------
    assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !bus_ack;

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= (AVS_READ_I || AVS_WRITE_I) && !bus_ack;
        end
    end

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
        merge16 = {be[1] ? new_v[15:8] : old_v[15:8],
                   be[0] ? new_v[7:0]  : old_v[7:0]};
    endfunction

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            slots_m1 <= `SSX_SLOTS_RST;
        end else if (AVS_WRITE_I && bus_ack && AVS_BYTEENABLE_I[0]
                     && AVS_ADDRESS_I == `SSX_OFF_CTRL) begin
            slots_m1 <= AVS_WRITEDATA_I[1:0];
        end
    end

    for (genvar s = 0; s < 4; s++) begin : g_wr
        always_ff @(posedge CLK_I or negedge rst_n) begin
            if (!rst_n) begin
                out_word[s] <= `SSX_WORD_RST;
                cmd_word[s] <= `SSX_WORD_RST;
            end else if (AVS_WRITE_I && bus_ack
                         && AVS_ADDRESS_I[7:5] == `SSX_REG_OUTW
                         && AVS_ADDRESS_I[4:3] == 2'(s)
                         && 2'(s) <= slots_m1) begin
                if (AVS_ADDRESS_I[2]) begin
                    cmd_word[s] <= merge16(cmd_word[s], AVS_WRITEDATA_I,
                                           AVS_BYTEENABLE_I);
                end else begin
                    out_word[s] <= merge16(out_word[s], AVS_WRITEDATA_I,
                                           AVS_BYTEENABLE_I);
                end
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (AVS_ADDRESS_I == `SSX_OFF_CTRL) begin
            next_rdata = {30'h0000_0000, slots_m1};
        end else if (AVS_ADDRESS_I == `SSX_OFF_TARE) begin
            next_rdata = {16'h0000, tare_reg};
        end else if (AVS_ADDRESS_I == `SSX_OFF_TARGET) begin
            next_rdata = {16'h0000, target_reg};
        end else if (AVS_ADDRESS_I == `SSX_OFF_MSG) begin
            next_rdata = {28'h000_0000, prompt_flag, disp_code};
        end else if (AVS_ADDRESS_I[7:5] == `SSX_REG_OUTW
                     && AVS_ADDRESS_I[4:3] <= slots_m1) begin
            next_rdata = {16'h0000, AVS_ADDRESS_I[2]
                          ? cmd_word[AVS_ADDRESS_I[4:3]]
                          : out_word[AVS_ADDRESS_I[4:3]]};
        end else if (AVS_ADDRESS_I[7:5] == `SSX_REG_INW
                     && AVS_ADDRESS_I[4:3] <= slots_m1) begin
            // busy bit is live so a read mid-update is flagged
            next_rdata = {16'h0000, AVS_ADDRESS_I[2]
                          ? (st_word[AVS_ADDRESS_I[4:3]]
                             | {1'b0, UPD_BUSY_O, 14'h0000})
                          : in_word[AVS_ADDRESS_I[4:3]]};
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            AVS_READDATA_O <= 32'h0000_0000;
        end else if (AVS_READ_I && !bus_ack) begin
            AVS_READDATA_O <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // state toward indicator logic
    // ------------------------------------------------------------
    assign TARGET_VAL_O   = target_reg;
    assign TARE_VAL_O     = tare_reg;
    assign NET_MODE_O     = net_mode;
    assign DISPLAY_CODE_O = disp_code;
    assign PROMPT_FLAG_O  = prompt_flag;

endmodule

/* ssx_exchange_assertions.sv */
/* Port checker of the slot integer exchange, bound into ssx_exchange.
   Assumes one clock and the async active-low reset of the top ports. */
`timescale 1ns/1ps
module ssx_checker (
    input wire logic        CLK_I,
    input wire logic        NRST_I,
    input wire logic        UPD_BUSY_O,
    input wire logic        CONV_TICK_I,
    input wire logic        ZERO_RANGE_OK_I,
    input wire logic        PRINT_REQ_O,
    input wire logic        ZERO_REQ_O,
    input wire logic        TGT_START_O,
    input wire logic        TGT_ABORT_O,
    input wire logic        NET_MODE_O,
    input wire logic [15:0] TARE_VAL_O,
    input wire logic [15:0] TARGET_VAL_O,
    input wire logic [2:0]  DOUT_O,
    input wire logic        MSG_START_O,
    input wire logic [2:0]  DISPLAY_CODE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    sequence busy_run;
        UPD_BUSY_O [*2] ##1 !UPD_BUSY_O;
    endsequence
    sequence code_shown;
        ##[0:1] (DISPLAY_CODE_O != 3'h0);
    endsequence
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    a_busy_two_cycles: assert property ($rose(UPD_BUSY_O) |-> busy_run)
        else $error("busy window length wrong");
    a_print_after_upd: assert property (PRINT_REQ_O |-> $past(UPD_BUSY_O))
        else $error("print outside update");
    a_print_one_pulse: assert property (PRINT_REQ_O |=> !PRINT_REQ_O)
        else $error("print pulse too long");
    a_zero_in_range: assert property (ZERO_REQ_O |-> $past(ZERO_RANGE_OK_I))
        else $error("zero outside range");
    a_target_edge_pulse: assert property ((TGT_START_O || TGT_ABORT_O) |->
        $past(UPD_BUSY_O) && !(TGT_START_O && TGT_ABORT_O))
        else $error("target start or abort wrong");
    a_tare_on_update: assert property (($changed(NET_MODE_O) || $changed(TARE_VAL_O)) |->
        $past(UPD_BUSY_O))
        else $error("tare state moved outside update");
    a_target_on_update: assert property ($changed(TARGET_VAL_O) |-> $past(UPD_BUSY_O))
        else $error("target moved outside update");
    a_dout_conv_rate: assert property ($changed(DOUT_O) |-> $past(CONV_TICK_I))
        else $error("outputs moved off conversion tick");
    a_msg_code_set: assert property (MSG_START_O |-> code_shown)
        else $error("message without code");
endmodule

bind ssx_exchange ssx_checker ssx_checker_i (
    .CLK_I(CLK_I), .NRST_I(NRST_I), .UPD_BUSY_O(UPD_BUSY_O), .CONV_TICK_I(CONV_TICK_I),
    .ZERO_RANGE_OK_I(ZERO_RANGE_OK_I), .PRINT_REQ_O(PRINT_REQ_O), .ZERO_REQ_O(ZERO_REQ_O),
    .TGT_START_O(TGT_START_O), .TGT_ABORT_O(TGT_ABORT_O), .NET_MODE_O(NET_MODE_O),
    .TARE_VAL_O(TARE_VAL_O), .TARGET_VAL_O(TARGET_VAL_O), .DOUT_O(DOUT_O),
    .MSG_START_O(MSG_START_O), .DISPLAY_CODE_O(DISPLAY_CODE_O));

/* ssx_tick_model.sv */
/* Update and conversion tick source standing for the indicator side.
   Assumes the bench clock; ticks are single-cycle pulses. */
`timescale 1ns/1ps
module ssx_tick_model (
    input  wire logic clk_i,
    output logic      upd_tick_o,
    output logic      conv_tick_o
);
    logic [4:0] cnt = 5'h00;
    initial upd_tick_o = 1'b0;
    initial conv_tick_o = 1'b0;
    always @(posedge clk_i) begin
        cnt <= cnt + 5'h01;
        upd_tick_o <= (cnt[3:0] == 4'h0);  // scan slower than conversion
        conv_tick_o <= (cnt[2:0] == 3'h3);
    end
endmodule

/* test_scale_slot_integer_exchange.sv */
/* Bench of the slot integer exchange: Avalon tasks and scenarios.
   Assumes ssx_exchange, ssx_tick_model and the bound checker. */
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_scale_slot_integer_exchange;
    logic        CLK_I = 1'b0, NRST_I = 1'b0, rd = 1'b0, wr = 1'b0, enter = 1'b0;
    logic        motion = 1'b0, zro = 1'b0, wt, upd, conv, prt, zrq, tst, tab, net;
    logic        msg, prompt, busy;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, q;
    logic [15:0] gross = 16'h0123, target, tare;
    logic [4:0]  cmp = 5'h00, flt = 5'h00;
    logic [2:0]  din = 3'h0, tgt = 3'h0, own_en = 3'h0, own = 3'h0, dout, code;
    int          miscompares = 0, total_checks = 0;
    int          n_print = 0, n_zero = 0, n_start = 0, n_abort = 0, n_msg = 0;

    always #12.5 CLK_I = ~CLK_I;
    always @(posedge CLK_I) begin
        n_print <= n_print + int'(prt);
        n_zero <= n_zero + int'(zrq);
        n_start <= n_start + int'(tst);
        n_abort <= n_abort + int'(tab);
        n_msg <= n_msg + int'(msg);
    end

    ssx_tick_model ssx_tick_model_i (.clk_i(CLK_I), .upd_tick_o(upd), .conv_tick_o(conv));
    ssx_exchange ssx_exchange_i (
        .CLK_I(CLK_I), .NRST_I(NRST_I), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wt), .UPD_TICK_I(upd),
        .CONV_TICK_I(conv), .GROSS_I(gross), .DISP_I(16'h0456), .RATE_I(16'h0789),
        .TGT_STATE_I(tgt), .CMP_I(cmp), .DIN_I(din), .ENTER_KEY_I(enter),
        .MOTION_I(motion), .POWERUP_I(flt[0]), .SETUP_I(flt[1]), .OVER_CAP_I(flt[2]),
        .UNDER_ZERO_I(flt[3]), .X10_I(flt[4]), .ZERO_RANGE_OK_I(zro),
        .OWN_OUT_EN_I(own_en), .OWN_OUT_I(own), .DOUT_O(dout), .PRINT_REQ_O(prt),
        .ZERO_REQ_O(zrq), .TGT_START_O(tst), .TGT_ABORT_O(tab), .TARGET_VAL_O(target),
        .TARE_VAL_O(tare), .NET_MODE_O(net), .MSG_START_O(msg), .DISPLAY_CODE_O(code),
        .PROMPT_FLAG_O(prompt), .UPD_BUSY_O(busy));

    // ----------------------------------------------------------------
    // bus and update tasks
    // ----------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_I);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        // the edge that sees waitrequest low completes; only the watchdog ends a hang
        do @(posedge CLK_I); while (wt);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, {16'h0000, d});
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        bus(1'b0, a, 32'h0000_0000);
        `CHK(q, {16'h0000, e})
    endtask
    // to the end of two update cycles, the first possibly already under way, so the latest command has surely been acted on
    task automatic sync();
        int n;
        n = 0;
        repeat (2) begin
            do @(negedge CLK_I); while (!busy && ++n < 200);
            do @(negedge CLK_I); while (busy && ++n < 200);
        end
        if (n >= 200) miscompares++;
        @(posedge CLK_I);
    endtask
    task automatic cmd(input logic [15:0] c);
        wreg(8'h24, c);
        sync();
    endtask
    function automatic logic [15:0] sel_exp(input int s);
        case (s)
            2: return 16'h0456;
            3, 4: return 16'h0000;
            5: return 16'h0789;
            default: return gross;
        endcase
    endfunction
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge CLK_I);
        miscompares++;
        finish_test();
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge CLK_I);
        NRST_I <= 1'b1;
        repeat (3) @(posedge CLK_I);
        rchk(8'h00, 16'h0000);
        wreg(8'h00, 16'h0003);
        rchk(8'h00, 16'h0003);
        rchk(8'h80, 16'h0000);
        for (int s = 0; s < 8; s++) begin
            cmd(16'(s));
            rchk(8'h40, sel_exp(s));
        end
        din <= 3'b101;
        cmp <= 5'b00011;
        tgt <= 3'b110;
        motion <= 1'b1;
        enter <= 1'b1;
        sync();
        enter <= 1'b0;
        cmd(16'h0020);
        rchk(8'h44, {4'b1001, 3'b101, 1'b1, 5'b11000, 3'b110});
        `CHK(net, 1'b0)
        motion <= 1'b0;
        cmd(16'h0000);
        cmd(16'h0020);
        `CHK(net, 1'b1)
        `CHK(tare, gross)
        cmd(16'h0010);
        `CHK({net, tare}, 17'h0_0000)
        wreg(8'h20, 16'h0040);
        cmd(16'h0009);
        `CHK(tare, 16'h0040)
        rchk(8'h40, gross - 16'h0040);
        wreg(8'h20, 16'h0777);
        cmd(16'h8000);
        `CHK(target, 16'h0777)
        wreg(8'h28, 16'h0555);
        wreg(8'h2C, 16'hfffb);
        sync();
        `CHK(target, 16'h0777)
        rchk(8'h48, 16'h0040);
        cmd(16'h00c0);
        `CHK(n_print, 1)
        `CHK(n_zero, 0)
        zro <= 1'b1;
        cmd(16'h0000);
        cmd(16'h0080);
        `CHK(n_zero, 1)
        cmd(16'h0100);
        cmd(16'h0000);
        `CHK({n_start, n_abort}, {32'd1, 32'd1})
        own_en <= 3'b010;
        cmd(16'h7000);
        `CHK(dout, 3'b101)
        for (int c = 1; c < 8; c++) begin
            cmd(16'(c) << 9);
            `CHK(code, 3'(c))
            cmd(16'h0000);
        end
        `CHK(n_msg, 7)
        `CHK(prompt, 1'b1)
        wreg(8'h0C, 16'h0008);
        rchk(8'h0C, 16'h0007);
        `CHK(prompt, 1'b0)
        bus(1'b0, 8'h44, 32'h0000_0000);
        `CHK(q[8], 1'b0)
        cmd(16'h0a00);
        cmd(16'h0c00);
        `CHK(n_msg, 8)
        cmd(16'h0000);
        for (int i = 0; i < 5; i++) begin
            flt <= 5'h01 << i;
            sync();
            rchk(8'h40, 16'h0000);
            bus(1'b0, 8'h44, 32'h0000_0000);
            `CHK(q[15], 1'b0)
        end
        finish_test();
    end
endmodule
